// ---- core/sec_pkg.sv ----
package sec_pkg;
  // organisation: 1 = word wide (16-bit data, 8-bit address), 0 = byte wide
  localparam int ADDR_W_BYTE = 9;
  localparam int ADDR_W_WORD = 8;
  localparam int DATA_W_BYTE = 8;
  localparam int DATA_W_WORD = 16;
  localparam int MEM_DEPTH = 512;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
  localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic PROG_EN_RESET = 1'b0;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CS_LOW_NS = 500;
  localparam int CS_LOW_CYCLES = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SK_HALF_NS = 1000;
  localparam int SK_HALF_CYCLES = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_MAX = 1 + 2 + 9 + 16;

  // address field width for the selected organisation
  function automatic int addr_width(input logic wordOrg);
    return wordOrg ? ADDR_W_WORD : ADDR_W_BYTE;
  endfunction : addr_width

  function automatic int data_width(input logic wordOrg);
    return wordOrg ? DATA_W_WORD : DATA_W_BYTE;
  endfunction : data_width
endpackage : sec_pkg

// ---- core/sec_link_if.sv ----
`timescale 1ns/1ps
interface sec_link_if;
  logic chipSel;
  logic shiftClock;
  logic dataIn;
  logic dataOut;
  logic dataOutEn;
  modport memory (input chipSel, input shiftClock, input dataIn, output dataOut, output dataOutEn);
  modport host (output chipSel, output shiftClock, output dataIn, input dataOut, input dataOutEn);
endinterface : sec_link_if

// ---- core/sec_memory.sv ----
`timescale 1ns/1ps
// Summary of operation
// - read is 1, 10, address; data returned
// - enable command 1,00,11x sets program latch
// - erase 1,11,address clears one location
// - write 1,01,address,data stores when enabled
// - erase-all 1,00,10x clears every location
// - write-all 1,00,01x,data fills every location
// - disable 1,00,00x blocks erase and write
// - host holds select low between instructions
module sec_memory
  import sec_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic clkEn, // freezes all state when low
  input wire logic wordOrg, // 1: word organisation
  sec_link_if.memory link // serial link
);
  typedef enum logic [1:0] {
    SEC_IDLE = 2'h0,
    SEC_SHIFT = 2'h1,
    SEC_READ = 2'h2,
    SEC_DONE = 2'h3
  } sec_mstate_t;

  logic [15:0] mem [MEM_DEPTH];
  logic cs1, cs2, sk1, sk2, di1, di2, skPrev_q;
  sec_mstate_t state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [27:0] sh_q, sh_d;
  logic progEn_q, progEn_d;
  logic [15:0] rd_q, rd_d;
  logic dout_q, dout_d, doutEn_q, doutEn_d;
  logic memWe, memAll;
  logic [8:0] memAddr;
  logic [15:0] memData;
  logic skRise, skFall;
  int aw, dw;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cs1, cs2, sk1, sk2, di1, di2, skPrev_q} <= 7'h00;
    end else if (clkEn) begin
      cs1 <= link.chipSel;
      cs2 <= cs1;
      sk1 <= link.shiftClock;
      sk2 <= sk1;
      di1 <= link.dataIn;
      di2 <= di1;
      skPrev_q <= sk2;
    end
  end

  assign skRise = sk2 && !skPrev_q;
  assign skFall = !sk2 && skPrev_q;
  assign aw = addr_width(wordOrg);
  assign dw = data_width(wordOrg);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    progEn_d = progEn_q;
    rd_d = rd_q;
    dout_d = dout_q;
    doutEn_d = doutEn_q;
    memWe = 1'b0;
    memAll = 1'b0;
    memAddr = 9'h000;
    memData = ERASED_WORD;
    if (!cs2) begin
      state_d = SEC_IDLE;
      cnt_d = 5'h00;
      sh_d = 28'h0000000;
      doutEn_d = 1'b0;
    end else begin
      unique case (state_q)
        SEC_IDLE: begin
          if (skRise && di2) begin
            state_d = SEC_SHIFT; // start bit
            cnt_d = 5'h00;
          end
        end
        SEC_SHIFT: begin
          if (skRise) begin
            sh_d = {sh_q[26:0], di2};
            cnt_d = cnt_q + 5'h01;
            if (int'(cnt_q) + 1 == 2 + aw) begin
              if (sh_d[aw +: 2] == OP_READ) begin
                rd_d = mem[wordOrg ? {1'b0, sh_d[7:0]} : sh_d[8:0]];
                state_d = SEC_READ;
                cnt_d = 5'h00;
              end else if (sh_d[aw +: 2] == OP_SPECIAL) begin
                state_d = SEC_DONE;
                unique case (wordOrg ? sh_d[7:6] : sh_d[8:7])
                  SUB_ENABLE: progEn_d = 1'b1;
                  SUB_DISABLE: progEn_d = 1'b0;
                  SUB_ERASE_ALL: begin
                    memAll = progEn_q;
                    memWe = progEn_q;
                  end
                  SUB_WRITE_ALL: state_d = SEC_SHIFT; // data follows
                endcase
              end else if (sh_d[aw +: 2] == OP_ERASE) begin
                memWe = progEn_q;
                memAddr = wordOrg ? {1'b0, sh_d[7:0]} : sh_d[8:0];
                state_d = SEC_DONE;
              end
            end else if (int'(cnt_q) + 1 == 2 + aw + dw) begin
              // op and address now sit dw bits higher
              state_d = SEC_DONE;
              memWe = progEn_q;
              memData = wordOrg ? sh_d[15:0] : {8'h00, sh_d[7:0]};
              memAddr = wordOrg ? {1'b0, sh_d[23:16]} : sh_d[16:8];
              memAll = (sh_d[(aw + dw) +: 2] == OP_SPECIAL);
            end
          end
        end
        SEC_READ: begin
          // leading dummy zero then msb first, changed after falling edge
          if (skFall) begin
            doutEn_d = 1'b1;
            dout_d = (cnt_q == 5'h00) ? 1'b0 : rd_q[15];
            if (cnt_q != 5'h00) begin
              rd_d = {rd_q[14:0], 1'b0};
            end else if (!wordOrg) begin
              rd_d = {rd_q[7:0], 8'h00};
            end
            cnt_d = cnt_q + 5'h01;
          end
        end
        SEC_DONE: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SEC_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 28'h0000000;
      progEn_q <= PROG_EN_RESET;
      rd_q <= 16'h0000;
      dout_q <= 1'b0;
      doutEn_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      progEn_q <= progEn_d;
      rd_q <= rd_d;
      dout_q <= dout_d;
      doutEn_q <= doutEn_d;
    end
  end

  // no reset on the array: it models nonvolatile contents
  always_ff @(posedge clk) begin
    if (clkEn && memWe) begin
      if (memAll) begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
          mem[i] <= memData;
        end
      end else begin
        mem[memAddr] <= memData;
      end
    end
  end

  assign link.dataOut = dout_q;
  assign link.dataOutEn = doutEn_q;
endmodule : sec_memory

// ---- core/sec_host.sv ----
`timescale 1ns/1ps
module sec_host
  import sec_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic clkEn, // freezes all state when low
  input wire logic wordOrg, // 1: word organisation
  input wire logic reqValid, // start an instruction
  output logic reqReady, // idle, may accept
  input wire logic [1:0] reqOp, // opcode
  input wire logic [8:0] reqAddr, // address field
  input wire logic [15:0] reqData, // write data
  output logic respValid, // one-cycle: instruction done
  output logic [15:0] respData, // read data
  sec_link_if.host link // serial link
);
  typedef enum logic [1:0] {
    SEC_H_IDLE = 2'h0,
    SEC_H_SEND = 2'h1,
    SEC_H_RECV = 2'h2,
    SEC_H_GAP = 2'h3
  } sec_hstate_t;

  sec_hstate_t state_q, state_d;
  logic [27:0] sh_q, sh_d;
  logic [4:0] bits_q, bits_d;
  logic [8:0] tim_q, tim_d;
  logic sk_q, sk_d, cs_q, cs_d;
  logic [15:0] rd_q, rd_d;
  logic done_q, done_d;
  logic do1, do2;
  int aw, dw;

  assign aw = addr_width(wordOrg);
  assign dw = data_width(wordOrg);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      do1 <= 1'b0;
      do2 <= 1'b0;
    end else if (clkEn) begin
      do1 <= link.dataOut;
      do2 <= do1;
    end
  end

  always_comb begin
    logic [27:0] frame;
    int nb;
    state_d = state_q;
    sh_d = sh_q;
    bits_d = bits_q;
    tim_d = tim_q;
    sk_d = sk_q;
    cs_d = cs_q;
    rd_d = rd_q;
    done_d = 1'b0;
    nb = 3 + aw;
    if (reqOp == OP_WRITE || (reqOp == OP_SPECIAL &&
        (wordOrg ? reqAddr[7:6] : reqAddr[8:7]) == SUB_WRITE_ALL)) begin
      nb = 3 + aw + dw;
    end
    // widen the head first so the start bit and opcode survive the shift
    frame = (28'({1'b1, reqOp}) << (aw + dw)) | (28'(reqAddr) << dw) | 28'(reqData);
    if (nb == 3 + aw) begin
      frame = frame >> dw;
    end
    frame = frame << (28 - nb);
    unique case (state_q)
      SEC_H_IDLE: begin
        if (reqValid) begin
          state_d = SEC_H_SEND;
          sh_d = frame;
          bits_d = 5'(nb);
          cs_d = 1'b1;
          tim_d = 9'h000;
        end
      end
      SEC_H_SEND: begin
        tim_d = tim_q + 9'h001;
        if (tim_q == 9'(SK_HALF_CYCLES - 1)) begin
          tim_d = 9'h000;
          sk_d = !sk_q;
          if (sk_q) begin
            sh_d = {sh_q[26:0], 1'b0};
            bits_d = bits_q - 5'h01;
            if (bits_q == 5'h01) begin
              if (reqOp == OP_READ) begin
                state_d = SEC_H_RECV;
                bits_d = 5'(dw + 1);
              end else begin
                state_d = SEC_H_GAP;
                cs_d = 1'b0;
                done_d = 1'b1;
              end
            end
          end
        end
      end
      SEC_H_RECV: begin
        tim_d = tim_q + 9'h001;
        if (tim_q == 9'(SK_HALF_CYCLES - 1)) begin
          tim_d = 9'h000;
          sk_d = !sk_q;
          if (!sk_q) begin
            // sample on rise, a half period after the memory changed it
            rd_d = {rd_q[14:0], do2};
            bits_d = bits_q - 5'h01;
          end else if (bits_q == 5'h00) begin
            state_d = SEC_H_GAP;
            cs_d = 1'b0;
            done_d = 1'b1;
          end
        end
      end
      SEC_H_GAP: begin
        tim_d = tim_q + 9'h001;
        if (tim_q == 9'(CS_LOW_CYCLES)) begin
          state_d = SEC_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SEC_H_IDLE;
      sh_q <= 28'h0000000;
      bits_q <= 5'h00;
      tim_q <= 9'h000;
      sk_q <= 1'b0;
      cs_q <= 1'b0;
      rd_q <= 16'h0000;
      done_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      sh_q <= sh_d;
      bits_q <= bits_d;
      tim_q <= tim_d;
      sk_q <= sk_d;
      cs_q <= cs_d;
      rd_q <= rd_d;
      done_q <= done_d;
    end
  end

  assign reqReady = (state_q == SEC_H_IDLE);
  assign respValid = done_q;
  assign respData = rd_q;
  assign link.chipSel = cs_q;
  assign link.shiftClock = sk_q;
  assign link.dataIn = sh_q[27];
endmodule : sec_host

// ---- bench/sec_link_sva.sv ----
`timescale 1ns/1ps
module sec_link_sva
  import sec_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic chipSel, // select
  input wire logic shiftClock, // shift clock
  input wire logic dataIn, // host to memory
  input wire logic dataOut, // memory to host
  input wire logic dataOutEn // memory drive enable
);
  logic [4:0] bitCnt_q, bitCnt_d;
  logic [2:0] head_q, head_d;
  logic [9:0] gap_q, gap_d;
  logic skOld_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_comb begin
    bitCnt_d = bitCnt_q;
    head_d = head_q;
    gap_d = chipSel ? 10'h000 : (gap_q == 10'h3FF ? gap_q : gap_q + 10'h001);
    // first high cycle of select still sees a nonzero gap count
    if (chipSel && gap_q != 10'h000) begin
      bitCnt_d = 5'h00;
    end else if (chipSel && shiftClock && !skOld_q) begin
      bitCnt_d = bitCnt_q + 5'h01;
      if (bitCnt_q < 5'h03) begin
        head_d = {head_q[1:0], dataIn};
      end
    end
  end
  // gap starts saturated so the first frame after reset is not flagged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bitCnt_q <= 5'h00;
      head_q <= 3'h0;
      gap_q <= 10'h3FF;
      skOld_q <= 1'b0;
    end else begin
      bitCnt_q <= bitCnt_d;
      head_q <= head_d;
      gap_q <= gap_d;
      skOld_q <= shiftClock;
    end
  end
  rise_in_frame_a: assert property ($rose(shiftClock) |-> chipSel)
    else $error("shift clock rose outside a frame");
  din_stable_a: assert property ($rose(shiftClock) |-> $stable(dataIn))
    else $error("data in moved at shift clock rise");
  cs_gap_a: assert property ($rose(chipSel) |-> gap_q >= CS_LOW_CYCLES)
    else $error("select low time too short");
  dout_idle_a: assert property (!chipSel [*4] |-> !dataOutEn)
    else $error("memory drives while deselected");
  dout_start_a: assert property ($rose(dataOutEn) |-> bitCnt_q == 5'h0C && head_q == 3'h6)
    else $error("read data started at wrong bit");
  dummy_zero_a: assert property ($rose(dataOutEn) |-> !dataOut)
    else $error("read dummy bit not zero");
  frame_len_a: assert property ($fell(chipSel) |-> bitCnt_q inside {5'h0C, 5'h14, 5'h15})
    else $error("frame bit count wrong");
  cs_sk_low_a: assert property ($fell(chipSel) |-> !shiftClock)
    else $error("select dropped with shift clock high");
endmodule : sec_link_sva

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb
  import sec_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic reqValid = 1'b0;
  logic [1:0] reqOp = 2'h0;
  logic [8:0] reqAddr = 9'h000;
  logic [15:0] reqData = 16'h0000;
  logic reqReady;
  logic respValid;
  logic [15:0] respData;
  logic [31:0] frm = 32'h0;
  logic skPrev = 1'b0;
  logic csPrev = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  sec_link_if u_sec_link_if ();
  sec_host u_sec_host (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .wordOrg(1'b0),
    .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .respValid(respValid), .respData(respData), .link(u_sec_link_if));
  sec_memory u_sec_memory (.clk(clk), .rst_b(rst_b), .clkEn(1'b1), .wordOrg(1'b0),
    .link(u_sec_link_if));
  sec_link_sva u_sec_link_sva (.clk(clk), .rst_b(rst_b), .chipSel(u_sec_link_if.chipSel),
    .shiftClock(u_sec_link_if.shiftClock), .dataIn(u_sec_link_if.dataIn),
    .dataOut(u_sec_link_if.dataOut), .dataOutEn(u_sec_link_if.dataOutEn));
  always #2.5 clk = ~clk;
  // wire monitor: bits seen at shift clock rises since select rose
  always @(posedge clk) begin
    if (u_sec_link_if.chipSel && !csPrev) begin
      frm <= 32'h0;
    end else if (u_sec_link_if.chipSel && u_sec_link_if.shiftClock && !skPrev) begin
      frm <= {frm[30:0], u_sec_link_if.dataIn};
    end
    skPrev <= u_sec_link_if.shiftClock;
    csPrev <= u_sec_link_if.chipSel;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check_val
  // automatic so that the watched signal can be passed by reference
  task automatic wait_hi(ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      check_val(32'h0, 32'h1);
      give_verdict();
    end
  endtask : wait_hi
  // request held until the accepting edge has passed; fields kept until done
  task xfer(input logic [1:0] op, input logic [8:0] addr, input logic [7:0] data);
    @(negedge clk);
    reqValid = 1'b1;
    reqOp = op;
    reqAddr = addr;
    reqData = {8'h00, data};
    wait_hi(reqReady, 1000);
    @(negedge clk);
    reqValid = 1'b0;
    wait_hi(respValid, 20000);
  endtask : xfer
  task rd(input logic [8:0] addr, input logic [7:0] exp);
    xfer(OP_READ, addr, 8'h00);
    check_val({24'h0, respData[7:0]}, {24'h0, exp});
  endtask : rd
  task t_program;
    xfer(OP_SPECIAL, {SUB_ENABLE, 7'h00}, 8'h00);
    xfer(OP_WRITE, 9'h1A5, 8'h3C);
    check_val(frm, {12'h000, 1'b1, OP_WRITE, 9'h1A5, 8'h3C});
    xfer(OP_WRITE, 9'h05A, 8'hC3);
    rd(9'h05A, 8'hC3);
    $display("program done");
  endtask : t_program
  task t_erase_one;
    xfer(OP_ERASE, 9'h1A5, 8'h00);
    rd(9'h1A5, ERASED_WORD[7:0]);
    rd(9'h05A, 8'hC3);
    $display("erase one done");
  endtask : t_erase_one
  task t_disable;
    xfer(OP_SPECIAL, {SUB_DISABLE, 7'h7F}, 8'h00);
    xfer(OP_WRITE, 9'h05A, 8'h00);
    rd(9'h05A, 8'hC3);
    $display("disable done");
  endtask : t_disable
  task t_erase_all;
    xfer(OP_SPECIAL, {SUB_ENABLE, 7'h2B}, 8'h00);
    xfer(OP_SPECIAL, {SUB_ERASE_ALL, 7'h55}, 8'h00);
    rd(9'h05A, ERASED_WORD[7:0]);
    $display("erase all done");
  endtask : t_erase_all
  task t_write_all;
    xfer(OP_SPECIAL, {SUB_WRITE_ALL, 7'h2A}, 8'h96);
    rd(9'h1A5, 8'h96);
    $display("write all done");
  endtask : t_write_all
  initial begin
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    t_program();
    t_erase_one();
    t_disable();
    t_erase_all();
    t_write_all();
    give_verdict();
  end
endmodule : tb
